// *** hdl/pss_map.vh ***
`ifndef PSS_MAP_VH
`define PSS_MAP_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PSS_OFS_CTRL      8'h00
`define PSS_OFS_FB_LOW    8'h04
`define PSS_OFS_FB_HIGH   8'h08
`define PSS_OFS_SLEEP     8'h0C
`define PSS_OFS_TARGET    8'h10
`define PSS_OFS_LIMITS    8'h14
`define PSS_OFS_USER_DISP 8'h18
`define PSS_OFS_FALLBACK  8'h1C
`define PSS_OFS_STATUS    8'h20
`define PSS_OFS_FREQ_MON  8'h24
`define PSS_OFS_TGT_MON   8'h28

// ------------------------------------------------------------
// control register field positions
// ------------------------------------------------------------
`define PSS_CTRL_ACT_LSB    0
`define PSS_CTRL_UNIT_LSB   3
`define PSS_CTRL_STEN_BIT   5
`define PSS_CTRL_MON_BIT    6
`define PSS_CTRL_REV2_BIT   7
`define PSS_CTRL_MODE_LSB   8
`define PSS_CTRL_STOP_LSB   11
`define PSS_CTRL_REVPRO_BIT 13
`define PSS_CTRL_FCLR_BIT   14

// ------------------------------------------------------------
// reset values (levels 0.01 %, times 0.1 s, freq 0.1 Hz)
// ------------------------------------------------------------
`define PSS_RST_FB_LOW_LEVEL  16'h0000
`define PSS_RST_FB_LOW_TIME   8'h0A
`define PSS_RST_FB_HIGH_LEVEL 16'h2710
`define PSS_RST_FB_HIGH_TIME  8'h0A
`define PSS_RST_SLEEP_FREQ    16'h0000
`define PSS_RST_SLEEP_DELAY   8'h00
`define PSS_RST_RAMP_TIME     8'h00
`define PSS_RST_TARGET        16'h0000
`define PSS_RST_UNIT          2'h1
`define PSS_RST_REV2          1'b1
`define PSS_RST_OUT_MIN       16'h0000
`define PSS_RST_IN_LIMIT      16'h2710
`define PSS_RST_FULLSCALE     16'h2710
`define PSS_RST_DECIMALS      2'h2
`define PSS_RST_FALLBACK      16'h012C
`define PSS_FULL_SCALE        16'h2710
`define PSS_UNIT_USER         2'h3

// ------------------------------------------------------------
// timing: 0.1 s tick at 40 MHz
// ------------------------------------------------------------
`define PSS_CLK_HZ       40000000
`define PSS_TICK_MS      100
`define PSS_TICK_CYCLES  ((`PSS_CLK_HZ / 1000) * `PSS_TICK_MS)

`endif

// *** hdl/pss_pid_supervision.v ***
// What this block does
// - feedback below low level longer than low time raises feedback-loss flag
// - low time 0 to 25.5 s in 0.1 s steps, default 1 s
// - sleep when compared frequency stays below start level longer than delay
// - while asleep, wake when compared frequency stays above level longer than delay
// - sleep delay 0 to 25.5 s, default 0; zero disables sleep
// - sleep stops motor with the general stop method
// - target ramps over its own time; ignored if soft-start input assigned
// - target selection 1 uses stored target, 0 ignores it, default 0
// - stored target used only when selected and no analog target source
// - display unit 0 Hz, 1 percent, 2 rpm, 3 user; default 1
// - output clamped to signed minimum; 0.00 percent disables clamp
// - PID input limited symmetrically to magnitude up to 1000.0 percent
// - feedback above high level longer than high time raises high flag
// - high time 0 to 25.5 s, default 1 s
// - full-scale value and decimals writable only with user-defined units
// - reference monitor shows post-PID value at 0 with PID enabled, plain reference otherwise
// - reverse select 0 clamps negative output to zero and stops; 1 reverses
// - trim modes 3 and 4 ignore reverse select and leave output unlimited
// - reverse prohibit makes reverse select two ignored
// - feedback-loss alarm runs fallback frequency, PID resumes on clear
// - sleep level and fallback capped by the frequency bound
// - action select picks output-only, alarm, fault and their variants
`timescale 1ns/100ps
`default_nettype none
`include "pss_map.vh"

module pss_pid_supervision #(
   parameter TICK_CYCLES = `PSS_TICK_CYCLES
) (
   input  wire               pclk,
   input  wire               presetn,
   input  wire               psel,
   input  wire               penable,
   input  wire               pwrite,
   input  wire [7:0]         paddr,
   input  wire [31:0]        pwdata,
   output reg  [31:0]        prdata,
   output wire               pready,
   output reg                pslverr,
   input  wire [15:0]        feedback,
   input  wire               drive_running,
   input  wire               pid_enabled,
   input  wire               soft_start_assigned,
   input  wire               analog_target_assigned,
   input  wire [15:0]        analog_target,
   input  wire [15:0]        sleep_compare_freq,
   input  wire signed [17:0] pid_input,
   input  wire signed [15:0] pid_output,
   input  wire [15:0]        freq_reference,
   input  wire [15:0]        freq_ref_after_pid,
   input  wire [15:0]        max_output_freq,
   input  wire [15:0]        motor_two_max_freq,
   input  wire [15:0]        freq_cmd_upper_limit,
   output reg  signed [17:0] pid_input_limited,
   output reg  signed [15:0] pid_output_limited,
   output reg                reverse_run,
   output reg  [15:0]        pid_target,
   output reg  [15:0]        freq_ref_monitor,
   output reg  [15:0]        freq_command_out,
   output reg                fb_low_out,
   output reg                fb_high_out,
   output reg                feedback_loss_alarm,
   output reg                feedback_high_alarm,
   output reg                fault_stop,
   output reg                sleep_active,
   output reg                motor_stop_req,
   output reg  [1:0]         stop_method,
   output reg  [1:0]         display_unit,
   output reg  [15:0]        user_fullscale,
   output reg  [1:0]         user_decimals
);

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   reg  [2:0]  detection_action_sel, pid_mode_sel;
   reg  [1:0]  display_unit_sel, stop_method_sel, user_decimal_places;
   reg         stored_target_enable, ref_monitor_content_sel, reverse_permit_sel_two, reverse_prohibit_sel;
   reg  [15:0] fb_low_level, fb_high_level, sleep_start_freq, stored_target_value;
   reg  [15:0] output_min_clamp, input_bipolar_limit, user_fullscale_value, fallback_frequency;
   reg  [7:0]  fb_low_time, fb_high_time, sleep_delay, target_ramp_time;
   // supervision state
   reg  [31:0] tick_cnt;
   reg  [8:0]  low_cnt, high_cnt, sleep_cnt;
   reg         tick, low_flag, high_flag, fault_latched;

   wire        setup_ph  = psel & ~penable;
   wire        wr_access = psel & penable & pwrite;
   wire        fault_clear = wr_access & (paddr == `PSS_OFS_CTRL) & pwdata[`PSS_CTRL_FCLR_BIT];

   // zero-wait slave: read data and error are captured in the setup cycle
   assign pready = 1'b1;

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         detection_action_sel    <= 3'h0;
         display_unit_sel        <= `PSS_RST_UNIT;
         stored_target_enable    <= 1'b0;
         ref_monitor_content_sel <= 1'b0;
         reverse_permit_sel_two  <= `PSS_RST_REV2;
         pid_mode_sel            <= 3'h0;
         stop_method_sel         <= 2'h0;
         reverse_prohibit_sel    <= 1'b0;
         fb_low_level            <= `PSS_RST_FB_LOW_LEVEL;
         fb_low_time             <= `PSS_RST_FB_LOW_TIME;
         fb_high_level           <= `PSS_RST_FB_HIGH_LEVEL;
         fb_high_time            <= `PSS_RST_FB_HIGH_TIME;
         sleep_start_freq        <= `PSS_RST_SLEEP_FREQ;
         sleep_delay             <= `PSS_RST_SLEEP_DELAY;
         stored_target_value     <= `PSS_RST_TARGET;
         target_ramp_time        <= `PSS_RST_RAMP_TIME;
         output_min_clamp        <= `PSS_RST_OUT_MIN;
         input_bipolar_limit     <= `PSS_RST_IN_LIMIT;
         user_fullscale_value    <= `PSS_RST_FULLSCALE;
         user_decimal_places     <= `PSS_RST_DECIMALS;
         fallback_frequency      <= `PSS_RST_FALLBACK;
      end else if (wr_access) begin
         if (paddr == `PSS_OFS_CTRL) begin
            detection_action_sel    <= pwdata[`PSS_CTRL_ACT_LSB +: 3];
            display_unit_sel        <= pwdata[`PSS_CTRL_UNIT_LSB +: 2];
            stored_target_enable    <= pwdata[`PSS_CTRL_STEN_BIT];
            ref_monitor_content_sel <= pwdata[`PSS_CTRL_MON_BIT];
            reverse_permit_sel_two  <= pwdata[`PSS_CTRL_REV2_BIT];
            pid_mode_sel            <= pwdata[`PSS_CTRL_MODE_LSB +: 3];
            stop_method_sel         <= pwdata[`PSS_CTRL_STOP_LSB +: 2];
            reverse_prohibit_sel    <= pwdata[`PSS_CTRL_REVPRO_BIT];
         end else if (paddr == `PSS_OFS_FB_LOW) begin
            fb_low_level <= pwdata[15:0];
            fb_low_time  <= pwdata[23:16];
         end else if (paddr == `PSS_OFS_FB_HIGH) begin
            fb_high_level <= pwdata[15:0];
            fb_high_time  <= pwdata[23:16];
         end else if (paddr == `PSS_OFS_SLEEP) begin
            sleep_start_freq <= pwdata[15:0];
            sleep_delay      <= pwdata[23:16];
         end else if (paddr == `PSS_OFS_TARGET) begin
            stored_target_value <= pwdata[15:0];
            target_ramp_time    <= pwdata[23:16];
         end else if (paddr == `PSS_OFS_LIMITS) begin
            output_min_clamp    <= pwdata[15:0];
            input_bipolar_limit <= pwdata[31:16];
         end else if (paddr == `PSS_OFS_USER_DISP) begin
            // locked unless user-defined units are selected
            if (display_unit_sel == `PSS_UNIT_USER) begin
               user_fullscale_value <= pwdata[15:0];
               user_decimal_places  <= pwdata[17:16];
            end
         end else if (paddr == `PSS_OFS_FALLBACK) begin
            fallback_frequency <= pwdata[15:0];
         end
      end
   end

   // ------------------------------------------------------------
   // register reads, captured in setup so prdata is a flop
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup_ph) begin
         pslverr <= 1'b0;
         if (paddr == `PSS_OFS_CTRL) begin
            prdata <= {18'h00000, reverse_prohibit_sel, stop_method_sel, pid_mode_sel,
                       reverse_permit_sel_two, ref_monitor_content_sel, stored_target_enable,
                       display_unit_sel, detection_action_sel};
         end else if (paddr == `PSS_OFS_FB_LOW) begin
            prdata <= {8'h00, fb_low_time, fb_low_level};
         end else if (paddr == `PSS_OFS_FB_HIGH) begin
            prdata <= {8'h00, fb_high_time, fb_high_level};
         end else if (paddr == `PSS_OFS_SLEEP) begin
            prdata <= {8'h00, sleep_delay, sleep_start_freq};
         end else if (paddr == `PSS_OFS_TARGET) begin
            prdata <= {8'h00, target_ramp_time, stored_target_value};
         end else if (paddr == `PSS_OFS_LIMITS) begin
            prdata <= {input_bipolar_limit, output_min_clamp};
         end else if (paddr == `PSS_OFS_USER_DISP) begin
            prdata <= {14'h0000, user_decimal_places, user_fullscale_value};
         end else if (paddr == `PSS_OFS_FALLBACK) begin
            prdata <= {16'h0000, fallback_frequency};
         end else if (paddr == `PSS_OFS_STATUS) begin
            prdata <= {26'h0000000, reverse_run, feedback_loss_alarm, fault_latched,
                       sleep_active, high_flag, low_flag};
         end else if (paddr == `PSS_OFS_FREQ_MON) begin
            prdata <= {16'h0000, freq_ref_monitor};
         end else if (paddr == `PSS_OFS_TGT_MON) begin
            prdata <= {16'h0000, pid_target};
         end else begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // 0.1 s tick shared by all persistence timers
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= 32'h00000000;
         tick     <= 1'b0;
      end else if (tick_cnt == TICK_CYCLES - 1) begin
         tick_cnt <= 32'h00000000;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h00000001;
         tick     <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // detection conditions and action decode
   // ------------------------------------------------------------
   wire act_pid_off  = (detection_action_sel >= 3'h3) && (detection_action_sel <= 3'h5);
   wire detect_on    = (detection_action_sel == 3'h7) ||
                       (drive_running && (pid_enabled || act_pid_off));
   wire act_alarm    = (detection_action_sel == 3'h1) || (detection_action_sel == 3'h4);
   wire act_fault    = (detection_action_sel == 3'h2) || (detection_action_sel == 3'h5);
   wire low_cond     = detect_on && (feedback < fb_low_level);
   wire high_cond    = detect_on && (feedback > fb_high_level);
   wire low_hit      = low_cond  && (low_cnt  > {1'b0, fb_low_time});
   wire high_hit     = high_cond && (high_cnt > {1'b0, fb_high_time});

   // frequency bound is the smallest of the three limits
   wire [15:0] bound_a   = (max_output_freq < motor_two_max_freq) ? max_output_freq : motor_two_max_freq;
   wire [15:0] freq_cap  = (bound_a < freq_cmd_upper_limit) ? bound_a : freq_cmd_upper_limit;
   wire [15:0] sleep_eff = (sleep_start_freq > freq_cap) ? freq_cap : sleep_start_freq;
   wire [15:0] fall_eff  = (fallback_frequency > freq_cap) ? freq_cap : fallback_frequency;
   wire        sleep_en  = (sleep_delay != 8'h00);
   wire        sleep_cond = sleep_active ? (sleep_compare_freq > sleep_eff)
                                         : (sleep_compare_freq < sleep_eff);

   // ------------------------------------------------------------
   // persistence counters: low and high saturate, sleep restarts past its delay; all restart when condition drops
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt   <= 9'h000;
         high_cnt  <= 9'h000;
         sleep_cnt <= 9'h000;
      end else begin
         if (!low_cond)
            low_cnt <= 9'h000;
         else if (tick && low_cnt != 9'h1FF)
            low_cnt <= low_cnt + 9'h001;
         if (!high_cond)
            high_cnt <= 9'h000;
         else if (tick && high_cnt != 9'h1FF)
            high_cnt <= high_cnt + 9'h001;
         // state flip also restarts the sleep count
         if (!sleep_cond || !sleep_en || (sleep_cnt > {1'b0, sleep_delay}))
            sleep_cnt <= 9'h000;
         else if (tick)
            sleep_cnt <= sleep_cnt + 9'h001;
      end
   end

   // ------------------------------------------------------------
   // flags, fault latch and sleep state
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_flag      <= 1'b0;
         high_flag     <= 1'b0;
         fault_latched <= 1'b0;
         sleep_active  <= 1'b0;
      end else begin
         // a latched fault holds both flags until software clears it
         if (low_hit)
            low_flag <= 1'b1;
         else if (!low_cond && !fault_latched)
            low_flag <= 1'b0;
         if (high_hit)
            high_flag <= 1'b1;
         else if (!high_cond && !fault_latched)
            high_flag <= 1'b0;
         // set beats clear when both land in one cycle
         if (act_fault && (low_hit || high_hit))
            fault_latched <= 1'b1;
         else if (fault_clear)
            fault_latched <= 1'b0;
         if (!sleep_en)
            sleep_active <= 1'b0;
         else if (sleep_cond && sleep_cnt > {1'b0, sleep_delay})
            sleep_active <= ~sleep_active;
      end
   end

   // ------------------------------------------------------------
   // target selection and ramp
   // ------------------------------------------------------------
   wire [15:0] target_src = (stored_target_enable && !analog_target_assigned) ?
                            stored_target_value : analog_target;
   wire        ramp_off   = (target_ramp_time == 8'h00) || soft_start_assigned;
   wire [15:0] ramp_step_w = `PSS_FULL_SCALE / {8'h00, target_ramp_time};
   wire [15:0] ramp_step   = ramp_off ? 16'h0001 : ramp_step_w;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pid_target <= 16'h0000;
      end else if (ramp_off) begin
         pid_target <= target_src;
      end else if (tick) begin
         // one step per tick reaches full scale in the ramp time
         if (target_src > pid_target)
            pid_target <= (target_src - pid_target > ramp_step) ? pid_target + ramp_step : target_src;
         else if (target_src < pid_target)
            pid_target <= (pid_target - target_src > ramp_step) ? pid_target - ramp_step : target_src;
      end
   end

   // ------------------------------------------------------------
   // input and output conditioning
   // ------------------------------------------------------------
   wire        trim_mode = (pid_mode_sel == 3'h3) || (pid_mode_sel == 3'h4);
   wire signed [17:0] in_lim  = $signed({2'b00, input_bipolar_limit}) * 18'sd10;
   wire signed [15:0] out_min = $signed(output_min_clamp);
   wire        no_reverse = reverse_prohibit_sel || !reverse_permit_sel_two;
   reg  signed [15:0] next_out;
   reg         next_neg_stop;

   always @* begin
      next_out      = pid_output;
      next_neg_stop = 1'b0;
      if (!trim_mode) begin
         if (output_min_clamp != 16'h0000 && pid_output < out_min)
            next_out = out_min;
         if (next_out < 16'sd0 && no_reverse) begin
            next_out      = 16'sd0;
            next_neg_stop = 1'b1;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pid_input_limited  <= 18'sd0;
         pid_output_limited <= 16'sd0;
         reverse_run        <= 1'b0;
      end else begin
         if (pid_input > in_lim)
            pid_input_limited <= in_lim;
         else if (pid_input < -in_lim)
            pid_input_limited <= -in_lim;
         else
            pid_input_limited <= pid_input;
         pid_output_limited <= next_out;
         reverse_run        <= !trim_mode && !no_reverse && (next_out < 16'sd0);
      end
   end

   // ------------------------------------------------------------
   // outputs toward the output stage and displays
   // ------------------------------------------------------------
   wire loss_alarm = low_flag && (act_alarm || act_fault);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freq_ref_monitor    <= 16'h0000;
         freq_command_out    <= 16'h0000;
         fb_low_out          <= 1'b0;
         fb_high_out         <= 1'b0;
         feedback_loss_alarm <= 1'b0;
         feedback_high_alarm <= 1'b0;
         fault_stop          <= 1'b0;
         motor_stop_req      <= 1'b0;
         stop_method         <= 2'h0;
         display_unit        <= `PSS_RST_UNIT;
         user_fullscale      <= `PSS_RST_FULLSCALE;
         user_decimals       <= `PSS_RST_DECIMALS;
      end else begin
         freq_ref_monitor <= (pid_enabled && !ref_monitor_content_sel) ?
                             freq_ref_after_pid : freq_reference;
         // fallback frequency while the loss alarm stands
         freq_command_out <= loss_alarm ? fall_eff : freq_reference;
         fb_low_out          <= low_flag;
         fb_high_out         <= high_flag;
         feedback_loss_alarm <= loss_alarm;
         feedback_high_alarm <= high_flag && (act_alarm || act_fault);
         fault_stop          <= fault_latched;
         motor_stop_req      <= sleep_active || fault_latched || next_neg_stop;
         stop_method         <= stop_method_sel;
         display_unit        <= display_unit_sel;
         user_fullscale      <= user_fullscale_value;
         user_decimals       <= user_decimal_places;
      end
   end

endmodule

`default_nettype wire

// *** sim/pss_pid_supervision_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module pss_chk (
   input wire logic               pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [7:0]         paddr,
   input wire logic [31:0]        pwdata,
   input wire logic               fault_stop, sleep_active, motor_stop_req,
   input wire logic [1:0]         display_unit, user_decimals,
   input wire logic [15:0]        user_fullscale,
   input wire logic signed [17:0] pid_input_limited
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // software clear is the only way out of a latched fault
   wire logic clr = psel && penable && pwrite && paddr == 8'h00 && pwdata[14];
   sequence s_acc;
      psel && penable;
   endsequence
   AST_READY: assert property (s_acc |-> pready) else $error("no ready");
   AST_UNMAPPED: assert property (s_acc ##0 paddr > 8'h28 |-> pslverr) else $error("no slave error");
   AST_SCALE_LOCK: assert property (!$stable(user_fullscale) |-> $past(display_unit) == 2'h3)
      else $error("scale written while locked");
   AST_DIGIT_LOCK: assert property (!$stable(user_decimals) |-> $past(display_unit) == 2'h3)
      else $error("digits written while locked");
   AST_IN_LIMIT: assert property (pid_input_limited <= 18'sh186A0 && pid_input_limited >= -18'sh186A0)
      else $error("input limit exceeded");
   AST_FAULT_STOP: assert property (fault_stop |-> ##[0:1] motor_stop_req) else $error("fault, no stop");
   // the output lags the latch by one cycle, so a clear shows two edges later
   AST_FAULT_HOLD: assert property (fault_stop && !clr && !$past(clr) |=> fault_stop)
      else $error("fault dropped");
   AST_SLEEP_STOP: assert property ($rose(sleep_active) |-> ##[0:2] motor_stop_req) else $error("sleep, no stop");
endmodule
bind pss_pid_supervision pss_chk u_chk (.*);
`default_nettype wire

// *** sim/pss_plant.sv ***
`timescale 1ns/100ps
`default_nettype none
// sensor follows its set point a clock late; the output stage runs unless told to stop
module pss_plant (
   input  wire logic        pclk, presetn, motor_stop_req,
   input  wire logic [15:0] fb_set,
   output var  logic [15:0] feedback,
   output var  logic        drive_running
);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         feedback <= 16'h0000;
         drive_running <= 1'b0;
      end else begin
         feedback <= fb_set;
         drive_running <= !motor_stop_req;
      end
   end
endmodule
`default_nettype wire

// *** sim/test_pid_supervision_sleep.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_pid_supervision_sleep;
   logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic               pid_enabled = 1, soft_start_assigned = 0, analog_target_assigned = 0, sleep_active;
   logic               drive_running, fb_low_out, fb_high_out, feedback_loss_alarm, fault_stop, motor_stop_req;
   logic [7:0]         paddr = 0;
   logic [31:0]        pwdata = 0, prdata, rd;
   logic [15:0]        analog_target, pid_output, freq_reference, freq_ref_after_pid, max_output_freq;
   logic [15:0]        motor_two_max_freq, freq_cmd_upper_limit, feedback, freq_command_out, user_fullscale;
   logic [15:0]        sleep_compare_freq = 16'h01F4, fb_set = 16'h1770;
   logic [15:0]        pid_target, freq_ref_monitor, pid_output_limited;
   logic               reverse_run, feedback_high_alarm;
   logic [1:0]         display_unit, user_decimals;
   logic signed [17:0] pid_input = 0, pid_input_limited;
   int                 n_errors = 0, n_compared = 0, i;
   localparam logic [7:0]  OFS [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h1C, 8'h40};
   localparam logic [31:0] RST [7] = '{32'h88, 32'hA_0000, 32'hA_2710, '0, 32'h2710_0000, 32'h12C, '0};
   always #12.5 pclk = ~pclk;
   pss_pid_supervision #(.TICK_CYCLES(10)) dut (.*, .stop_method());
   pss_plant plant (.*);
   task end_sim;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // setup edge, then access edges until pready; request held until that edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk) penable <= 1'b1;
      for (k = 0; k < 9; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      chk(k < 9, 1);
      if (k == 9) end_sim;
   endtask
   // write control, let the output path settle, then look at it
   task po(input logic [31:0] c, input logic [15:0] e, input logic r);
      apb(1, 8'h00, c);
      repeat (2) @(negedge pclk);
      chk(pid_output_limited, e);
      chk(reverse_run, r);
   endtask
   // poll at falling edges so registered outputs have settled
   task wsig(input int s, input logic v);
      int k;
      logic [3:0] st;
      for (k = 0; k < 999; k++) begin
         @(negedge pclk);
         st = {fault_stop, fb_high_out, sleep_active, fb_low_out};
         if (st[s] === v) break;
      end
      chk(st[s], v);
      if (k == 999) end_sim;
   endtask
   function logic signed [17:0] lim(input logic signed [17:0] x);
      return x > 18'sh186A0 ? 18'sh186A0 : x < -18'sh186A0 ? -18'sh186A0 : x;
   endfunction
   initial begin
      i = $urandom(89);
      {analog_target, pid_output, freq_reference, freq_ref_after_pid} = {$urandom, $urandom} & 64'h1FFF_0FFF_1FFF_1FFF;
      max_output_freq = 16'h0258 + 16'($urandom % 999);
      {motor_two_max_freq, freq_cmd_upper_limit} = {2{max_output_freq}};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 7; i++) begin
         apb(0, OFS[i], 0);
         chk(rd, RST[i]);
         chk(er, i == 6);
      end
      apb(1, 8'h18, 32'h1_1234);
      apb(0, 8'h18, 0);
      chk(rd, 32'h2_2710);
      apb(1, 8'h00, 32'h99);
      apb(1, 8'h18, 32'h1_1234);
      apb(0, 8'h18, 0);
      chk(rd, 32'h1_1234);
      for (i = 0; i < 12; i++) begin
         @(posedge pclk) pid_input <= i == 0 ? 18'sh1FFFF : i == 1 ? 18'sh20000 : 18'($urandom);
         repeat (2) @(posedge pclk);
         @(negedge pclk) chk(pid_input_limited, lim(pid_input));
      end
      apb(1, 8'h04, 32'h3_1388);
      @(posedge pclk) fb_set <= 16'($urandom % 5000);
      repeat (25) @(negedge pclk);
      chk(fb_low_out, 0);
      wsig(0, 1);
      repeat (3) @(negedge pclk);
      chk(feedback_loss_alarm, 1);
      chk(freq_command_out, 16'h012C);
      apb(1, 8'h1C, 32'hFFFF);
      repeat (2) @(negedge pclk);
      chk(freq_command_out, max_output_freq);
      @(posedge pclk) fb_set <= 16'h1770;
      wsig(0, 0);
      @(posedge pclk) fb_set <= 16'h2711 + 16'($urandom % 5000);
      wsig(2, 1);
      chk(feedback_high_alarm, 1);
      @(posedge pclk) fb_set <= 16'h1770;
      wsig(2, 0);
      apb(1, 8'h00, 32'h9A);
      @(posedge pclk) fb_set <= 16'h0010;
      wsig(3, 1);
      @(posedge pclk) fb_set <= 16'h1770;
      repeat (60) @(negedge pclk);
      chk(fault_stop, 1);
      apb(1, 8'h00, 32'h409A);
      wsig(3, 0);
      apb(1, 8'h0C, 32'h2_0064);
      @(posedge pclk) sleep_compare_freq <= 16'h0032;
      wsig(2'h2 - 1, 1);
      @(posedge pclk) sleep_compare_freq <= 16'h00C8;
      wsig(1, 0);
      apb(1, 8'h0C, 32'h64);
      @(posedge pclk) sleep_compare_freq <= 16'h0032;
      repeat (80) @(negedge pclk);
      chk(sleep_active, 0);
      @(posedge pclk) pid_output <= 16'hFF00;
      po(32'h9A, 16'hFF00, 1);
      po(32'h1A, 16'h0000, 0);
      po(32'h31A, 16'hFF00, 0);
      po(32'h209A, 16'h0000, 0);
      apb(1, 8'h14, 32'h2710_FF80);
      po(32'h9A, 16'hFF80, 1);
      chk(freq_ref_monitor, freq_ref_after_pid);
      chk(pid_target, analog_target);
      po(32'hFA, 16'hFF80, 1);
      chk(freq_ref_monitor, freq_reference);
      chk(pid_target, 0);
      end_sim;
   end
endmodule
`default_nettype wire
